// ### design/output_voltage_target_control.sv
// Purpose: Output voltage target, reference ramp and discharge control
// Assumes: Single AHB-Lite slave, zero wait states, 250 MHz clock
// Notes:   Feedback comparator and enable pin arrive synchronous
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "vout_target_defines.svh"

module output_voltage_target_control
(
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic      [31:0] hrdata_out,
    input  wire logic        enable_in,
    input  wire logic        feedback_pin_high_in,
    output logic             feedback_internal_out,
    output logic             converter_run_out,
    output logic      [11:0] reference_code_out,
    output logic             discharge_enable_out,
    output logic      [1:0]  discharge_level_out,
    output logic             reverse_current_block_out
);

    vout_target_pkg::ctrl_state_s s_q;
    vout_target_pkg::ctrl_state_s s_d;

    logic        ready_q;
    logic [11:0] ref_code;
    logic        ramp_busy;
    logic        ramp_falling;
    logic [11:0] eff_target;
    logic [15:0] interval;
    logic        ramp_clear;

    ////////////////////////////////////////////////////////////////////////////////
    // Target code clamp

    // Stored code is kept as written; clamp applies on read and regulation
    function automatic logic [11:0] clamp_code
    (
        input logic [11:0] code,
        input logic        div_sel
    );
        logic [11:0] lo;
        logic [11:0] hi;
        lo = div_sel ? `CODE_MIN_HI : `CODE_MIN_LO;
        hi = div_sel ? `CODE_MAX_HI : `CODE_MAX_LO;
        if (code < lo)
        begin
            clamp_code = lo;
        end
        else if (code > hi)
        begin
            clamp_code = hi;
        end
        else
        begin
            clamp_code = code;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register read mux

    function automatic logic [31:0] read_mux
    (
        input logic [7:0]                    addr,
        input vout_target_pkg::ctrl_state_s  s,
        input logic [11:0]                   refc,
        input logic                          busy
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr)
            `REG_CTRL:
            begin
                v[`CTRL_RUN_BIT] = s.run_en;
                v[`CTRL_DIV_BIT] = s.div_sel;
                v[`CTRL_SAVE_BIT] = s.power_save;
            end
            `REG_TARGET:
            begin
                v[11:0] = clamp_code(s.target_code, s.div_sel);
            end
            `REG_DISCHARGE:
            begin
                v[1:0]                 = s.disch_level;
                v[`OVR_LSB+1:`OVR_LSB] = s.disch_override;
            end
            `REG_DISCH_SEQ_A:
            begin
                v[7:0] = s.seq_a;
            end
            `REG_DISCH_SEQ_B:
            begin
                v[7:0] = s.seq_b;
            end
            `REG_RAMP_CFG:
            begin
                v[7:0]              = s.slope_sel;
                v[`RAMP_ACTIVE_BIT] = s.active_ramp;
            end
            `REG_STATUS:
            begin
                v[`STAT_FB_BIT]    = s.fb_internal;
                v[`STAT_RUN_BIT]   = (s.state != vout_target_pkg::ST_OFF);
                v[`STAT_RAMP_BIT]  = busy;
                v[`STAT_DISCH_BIT] = s.disch_on;
                v[`STAT_REF_LSB+11:`STAT_REF_LSB] = refc;
            end
            default:
            begin
                v = 32'h0000_0000;
            end
        endcase
        read_mux = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reference ramp

    assign eff_target = clamp_code(s_q.target_code, s_q.div_sel);
    assign interval   = 16'((32'(s_q.slope_sel) + 32'h1) * `RAMP_BASE_CYC);
    // Off clears the reference so every start is a full soft-start
    assign ramp_clear = (s_q.state == vout_target_pkg::ST_OFF);

    // Soft-start and run share one stepper, so start always aims at the latest code
    reference_ramp u_ramp
    (
        .ref_clk_in  (ref_clk_in),
        .sys_rst_in  (sys_rst_in),
        .clear_in    (ramp_clear),
        .target_in   (eff_target),
        .interval_in (interval),
        .ref_out     (ref_code),
        .busy_out    (ramp_busy),
        .falling_out (ramp_falling)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        logic        go;
        logic        auto_on;
        logic        ramp_dis;
        logic [23:0] seq_delay;
        logic        ap;
        go        = 1'b0;
        auto_on   = 1'b0;
        ramp_dis  = 1'b0;
        seq_delay = 24'h000000;
        ap        = 1'b0;
        s_d       = s_q;

        // Data phase of an earlier write
        if (s_q.wr_pend)
        begin
            s_d.wr_pend = 1'b0;
            case (s_q.wr_addr)
                `REG_CTRL:
                begin
                    s_d.run_en  = hwdata_in[`CTRL_RUN_BIT];
                    s_d.div_sel = hwdata_in[`CTRL_DIV_BIT];
                    s_d.power_save = hwdata_in[`CTRL_SAVE_BIT];
                end
                `REG_TARGET:
                begin
                    // Raw code kept; a divider change re-clamps it with no host rewrite
                    s_d.target_code = hwdata_in[11:0];
                end
                `REG_DISCHARGE:
                begin
                    s_d.disch_level    = hwdata_in[1:0];
                    s_d.disch_override = hwdata_in[`OVR_LSB+1:`OVR_LSB];
                end
                `REG_DISCH_SEQ_A:
                begin
                    s_d.seq_a = hwdata_in[7:0];
                end
                `REG_DISCH_SEQ_B:
                begin
                    s_d.seq_b = hwdata_in[7:0];
                end
                `REG_RAMP_CFG:
                begin
                    s_d.slope_sel   = hwdata_in[7:0];
                    s_d.active_ramp = hwdata_in[`RAMP_ACTIVE_BIT];
                end
                default:
                begin
                    s_d.wr_pend = 1'b0;
                end
            endcase
        end

        // Address phase; read sees any write landing in this same cycle
        // Size is ignored; only whole words are mapped
        ap = hsel_in && htrans_in[1] && hready_in;
        if (ap && hwrite_in)
        begin
            s_d.wr_pend = 1'b1;
            s_d.wr_addr = haddr_in[7:0];
        end
        else if (ap)
        begin
            s_d.hrdata = read_mux(haddr_in[7:0], s_d, ref_code, ramp_busy);
        end

        // Converter sequencing
        go = s_q.run_en && enable_in;
        if (!enable_in)
        begin
            s_d.fb_valid = 1'b0;
        end
        case (s_q.state)
            vout_target_pkg::ST_OFF:
            begin
                if (go)
                begin
                    s_d.state = vout_target_pkg::ST_SOFTSTART;
                    // Latched once per enable cycle; run toggles keep it
                    if (!s_q.fb_valid)
                    begin
                        s_d.fb_internal = feedback_pin_high_in;
                        s_d.fb_valid    = 1'b1;
                    end
                end
            end
            vout_target_pkg::ST_SOFTSTART:
            begin
                if (!go)
                begin
                    s_d.state = vout_target_pkg::ST_OFF;
                end
                else if (!ramp_busy)
                begin
                    s_d.state = vout_target_pkg::ST_RUN;
                end
            end
            vout_target_pkg::ST_RUN:
            begin
                if (!go)
                begin
                    s_d.state = vout_target_pkg::ST_OFF;
                end
            end
            default:
            begin
                s_d.state = vout_target_pkg::ST_OFF;
            end
        endcase

        // Stop sequence: optional wait for enable pin, then delay, then discharge
        seq_delay = 24'(32'(s_q.seq_b) * `RAMP_BASE_CYC);
        if (s_q.state == vout_target_pkg::ST_OFF && s_q.seq_a[0]
            && (!s_q.seq_a[1] || !enable_in))
        begin
            if (s_q.disch_cnt >= seq_delay)
            begin
                auto_on = 1'b1;
            end
            else
            begin
                s_d.disch_cnt = s_q.disch_cnt + 24'h000001;
            end
        end
        else
        begin
            s_d.disch_cnt = 24'h000000;
        end

        // Passive mode leaves the falling ramp to the load alone
        ramp_dis = s_q.active_ramp && ramp_falling
                   && (s_q.state == vout_target_pkg::ST_RUN);

        case (s_q.disch_override)
            `OVR_FORCE_ON:
            begin
                s_d.disch_on = 1'b1;
            end
            `OVR_FORCE_OFF:
            begin
                s_d.disch_on = 1'b0;
            end
            default:
            begin
                s_d.disch_on = auto_on || ramp_dis;
            end
        endcase
        s_d.disch_strength = ramp_dis ? `DISCH_MAX_LEVEL : s_q.disch_level;

        s_d.rev_block = s_q.power_save && (s_q.state != vout_target_pkg::ST_OFF);

        // Registered so the run pin needs no decode
        s_d.running = (s_d.state != vout_target_pkg::ST_OFF);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            // Fields not listed reset to zero with the struct
            s_q                <= '0;
            s_q.state          <= vout_target_pkg::ST_OFF;
            s_q.target_code    <= `RST_TARGET;
            s_q.disch_level    <= `RST_LEVEL;
            s_q.seq_a          <= `RST_SEQ_A;
            s_q.seq_b          <= `RST_SEQ_B;
            s_q.slope_sel      <= `RST_SLOPE;
            ready_q            <= 1'b0;
        end
        else
        begin
            s_q     <= s_d;
            ready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Always ready after reset; the slave never inserts wait states
    assign hreadyout_out             = ready_q;
    assign hresp_out                 = 1'b0;
    assign hrdata_out                = s_q.hrdata;
    assign feedback_internal_out     = s_q.fb_internal;
    assign converter_run_out         = s_q.running;
    assign reference_code_out        = ref_code;
    assign discharge_enable_out      = s_q.disch_on;
    assign discharge_level_out       = s_q.disch_strength;
    assign reverse_current_block_out = s_q.rev_block;

endmodule

// ### design/vout_target_defines.svh
// Purpose: Constants for the output voltage target control block
// Assumes: 250 MHz ref_clk_in, AHB-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
//
// Behaviour
// - Feedback source chosen from feedback pin comparator, sampled before soft-start.
// - Feedback choice frozen until next enable cycle or power-on reset.
// - Divider bit clear: target 1.0V to 24V in 10mV steps.
// - Divider bit set: target 3.3V to 48V in 20mV steps.
// - Target code is four high-field bits above eight low-field bits.
// - Reading a code below minimum returns the minimum clamp code.
// - Reading a code above maximum returns the maximum clamp code.
// - Target change while running moves the reference gradually.
// - Ramp slope limited both ways; slope time from nonvolatile setting; here slope_sel in REG_RAMP_CFG, reset to zero.
// - Target written while off is used by next soft-start directly.
// - In power-save operation negative inductor current is blocked.
// - Passive or active ramping; active discharges during falling ramp only.
// - Active ramp-down uses maximum discharge strength, ignoring the register.
// - Discharge strength is selectable by register.
// - Discharge order and conditions follow two sequence registers.
// - Discharge override forces on or off over the sequence.
`ifndef VOUT_TARGET_DEFINES_SVH
`define VOUT_TARGET_DEFINES_SVH

// Register byte offsets
`define REG_CTRL          8'h00
`define REG_TARGET        8'h04
`define REG_DISCHARGE     8'h08
`define REG_DISCH_SEQ_A   8'h0C
`define REG_DISCH_SEQ_B   8'h10
`define REG_RAMP_CFG      8'h14
`define REG_STATUS        8'h18

// Field positions
`define CTRL_RUN_BIT      0
`define CTRL_DIV_BIT      1
`define CTRL_SAVE_BIT     2
`define RAMP_ACTIVE_BIT   8
`define OVR_LSB           2
`define STAT_FB_BIT       0
`define STAT_RUN_BIT      1
`define STAT_RAMP_BIT     2
`define STAT_DISCH_BIT    3
`define STAT_REF_LSB      16

// Override encodings
`define OVR_FORCE_ON      2'h1
`define OVR_FORCE_OFF     2'h2

// Reset values and maximum discharge level
`define RST_TARGET        12'h000
`define RST_LEVEL         2'h0
`define RST_SEQ_A         8'h01
`define RST_SEQ_B         8'h00
`define RST_SLOPE         8'h00
`define DISCH_MAX_LEVEL   2'h3

// Voltage scaling in millivolts
`define VMIN_LO_MV        1000
`define VMAX_LO_MV        24000
`define STEP_LO_MV        10
`define VMIN_HI_MV        3300
`define VMAX_HI_MV        48000
`define STEP_HI_MV        20
`define CODE_MIN_LO       12'(`VMIN_LO_MV / `STEP_LO_MV)
`define CODE_MAX_LO       12'(`VMAX_LO_MV / `STEP_LO_MV)
`define CODE_MIN_HI       12'(`VMIN_HI_MV / `STEP_HI_MV)
`define CODE_MAX_HI       12'(`VMAX_HI_MV / `STEP_HI_MV)

// Timing
`define CLK_PERIOD_NS     4
`define RAMP_BASE_NS      1000
`define RAMP_BASE_CYC     ((`RAMP_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### design/vout_target_pkg.sv
// Purpose: Types for the output voltage target control block
// Assumes: Constants come from vout_target_defines.svh
// Notes:   State structs hold every flip-flop of each module except the ready_q flag
package vout_target_pkg;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_SOFTSTART,
        ST_RUN
    } conv_state_e;

    typedef struct packed {
        logic [11:0] ref_code;
        logic [15:0] cnt;
        logic        falling;
    } ramp_state_s;

    typedef struct packed {
        conv_state_e state;
        logic        fb_valid;
        logic        fb_internal;
        logic        run_en;
        logic        div_sel;
        logic        power_save;
        logic        active_ramp;
        logic [7:0]  slope_sel;
        logic [11:0] target_code;
        logic [1:0]  disch_level;
        logic [1:0]  disch_override;
        logic [7:0]  seq_a;
        logic [7:0]  seq_b;
        logic [23:0] disch_cnt;
        logic        disch_on;
        logic [1:0]  disch_strength;
        logic        rev_block;
        logic        running;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] hrdata;
    } ctrl_state_s;

endpackage

// ### design/reference_ramp.sv
// Purpose: Slew-limited reference code stepper
// Assumes: interval_in is at least one cycle
// Notes:   One code step per interval, either direction
`timescale 1ns/1ps
`include "vout_target_defines.svh"

module reference_ramp
(
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clear_in,
    input  wire logic [11:0] target_in,
    input  wire logic [15:0] interval_in,
    output logic      [11:0] ref_out,
    output logic             busy_out,
    output logic             falling_out
);

    vout_target_pkg::ramp_state_s r_q;
    vout_target_pkg::ramp_state_s r_d;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        r_d = r_q;
        if (clear_in)
        begin
            r_d.ref_code = 12'h000;
            r_d.cnt      = 16'h0000;
            r_d.falling  = 1'b0;
        end
        else if (r_q.ref_code != target_in)
        begin
            // Step only after a full interval so slope never exceeds the limit
            r_d.falling = (target_in < r_q.ref_code);
            if (r_q.cnt >= interval_in - 16'h0001)
            begin
                r_d.cnt = 16'h0000;
                if (target_in < r_q.ref_code)
                begin
                    r_d.ref_code = r_q.ref_code - 12'h001;
                end
                else
                begin
                    r_d.ref_code = r_q.ref_code + 12'h001;
                end
            end
            else
            begin
                r_d.cnt = r_q.cnt + 16'h0001;
            end
        end
        else
        begin
            r_d.cnt     = 16'h0000;
            r_d.falling = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign ref_out     = r_q.ref_code;
    assign busy_out    = (r_q.ref_code != target_in);
    assign falling_out = r_q.falling;

endmodule

// ### bench/vout_target_checker_asserts.sv
// Purpose: Port-level checks on the output voltage target block
// Assumes: Slope setting left at zero, one reference step per 250 cycles
// Notes:   Sees only top-level ports
`timescale 1ns/1ps

module vout_target_checker
(
    input wire logic        ref_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        enable_in,
    input wire logic        feedback_pin_high_in,
    input wire logic        feedback_internal_out,
    input wire logic        converter_run_out,
    input wire logic [11:0] reference_code_out,
    input wire logic        discharge_enable_out,
    input wire logic [1:0]  discharge_level_out,
    input wire logic        reverse_current_block_out
);
    localparam int GAP = 249;
    logic [11:0] seen_q;
    logic [15:0] gap_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the reference last moved; saturates so it never wraps
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            seen_q <= 12'h000;
            gap_q  <= 16'h0000;
        end
        else
        begin
            seen_q <= reference_code_out;
            if (reference_code_out != seen_q)
                gap_q <= 16'h0000;
            else if (gap_q != 16'hFFFF)
                gap_q <= gap_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_ref_step: assert property (
        $changed(reference_code_out) && converter_run_out |->
        (reference_code_out == $past(reference_code_out) + 12'h001) ||
        (reference_code_out == $past(reference_code_out) - 12'h001))
        else $error("reference moved by more than one code");
    a_ref_gap: assert property (
        converter_run_out && $past(converter_run_out) && $changed(reference_code_out)
        |-> gap_q >= GAP)
        else $error("reference stepped too soon");
    a_ref_max: assert property (reference_code_out <= 12'h960)
        else $error("reference above top clamp");
    a_fb_frozen: assert property (
        enable_in && $past(enable_in) && $past(converter_run_out)
        |-> $stable(feedback_internal_out))
        else $error("feedback choice changed while running");
    a_fb_start: assert property (
        $rose(converter_run_out) && !$past(enable_in, 2)
        |-> feedback_internal_out == $past(feedback_pin_high_in))
        else $error("feedback choice not taken from pin at start");
    a_rev_block: assert property (
        reverse_current_block_out |-> $past(converter_run_out))
        else $error("reverse block while converter off");
    a_clear_off: assert property (
        !converter_run_out [*3] |-> reference_code_out == 12'h000)
        else $error("reference not cleared while off");
    a_run_enable: assert property (converter_run_out |-> $past(enable_in))
        else $error("converter running without enable");

    c_run: cover property ($rose(converter_run_out));
    c_active_down: cover property (discharge_enable_out && discharge_level_out == 2'h3);
    c_rev_block: cover property ($rose(reverse_current_block_out));
endmodule

bind output_voltage_target_control vout_target_checker u_checker
(
    .ref_clk_in,
    .sys_rst_in,
    .enable_in,
    .feedback_pin_high_in,
    .feedback_internal_out,
    .converter_run_out,
    .reference_code_out,
    .discharge_enable_out,
    .discharge_level_out,
    .reverse_current_block_out
);

// ### bench/ahb_host.sv
// Purpose: Configuration host issuing single AHB-Lite word transfers
// Assumes: One slave whose hreadyout is the bus hready
// Notes:   Released address and data lines show inverted values so stale data never matches
`timescale 1ns/1ps

module ahb_host
(
    input  wire logic        ref_clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    output logic             hsel_out,
    output logic      [31:0] haddr_out,
    output logic      [1:0]  htrans_out,
    output logic             hwrite_out,
    output logic      [2:0]  hsize_out,
    output logic      [31:0] hwdata_out
);
    initial
    begin
        hsel_out   = 1'b0;
        haddr_out  = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out  = 3'h2;
        hwdata_out = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge ref_clk_in);
        hsel_out   <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out  <= a;
        hwrite_out <= wr;
        @(posedge ref_clk_in);
        while (hready_in !== 1'b1)
            @(posedge ref_clk_in);
        hsel_out   <= 1'b0;
        htrans_out <= 2'h0;
        haddr_out  <= ~a;
        hwdata_out <= wr ? d : ~hwdata_out;
        @(posedge ref_clk_in);
        while (hready_in !== 1'b1)
            @(posedge ref_clk_in);
        q = hrdata_in;
        hwdata_out <= ~d;
    endtask
endmodule

// ### bench/testbench.sv
// Purpose: Self-checking bench for the output voltage target block
// Assumes: Slope 0, so one reference step per 250 cycles
// Notes:   Expected codes follow from millivolt limits over step size
`timescale 1ns/1ps
`include "vout_target_defines.svh"

module testbench;
    logic        ref_clk_in;
    logic        sys_rst_in;
    logic        enable_in;
    logic        fb_pin;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        fb_int;
    logic        run;
    logic [11:0] refc;
    logic        dis_en;
    logic [1:0]  dis_lvl;
    logic        rev_blk;
    int          num_errors;
    int          checks;
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    logic [31:0] rv [7] = '{32'h0, 32'h64, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
    logic        cd [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [31:0] cw [6] = '{32'h32, 32'hBB8, 32'h4D2, 32'h64, 32'hFFF, 32'hFFFFF5A5};
    logic [31:0] ce [6] = '{32'h64, 32'h960, 32'h4D2, 32'hA5, 32'h960, 32'h5A5};

    output_voltage_target_control DUT
    (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
        .hresp_out(hresp), .hrdata_out(hrdata), .enable_in(enable_in),
        .feedback_pin_high_in(fb_pin), .feedback_internal_out(fb_int),
        .converter_run_out(run), .reference_code_out(refc),
        .discharge_enable_out(dis_en), .discharge_level_out(dis_lvl),
        .reverse_current_block_out(rev_blk)
    );

    ahb_host host
    (
        .ref_clk_in(ref_clk_in), .hready_in(hready), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
        .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata)
    );

    always #2 ref_clk_in = ~ref_clk_in;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, {24'h0, a}, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        host.xfer(1'b0, {24'h0, a}, 32'h0, q);
    endtask

    // Bounded wait: soft-start from zero can take over 25000 cycles
    task automatic wait_ref(input logic [11:0] v);
        int n;
        n = 0;
        while (refc !== v && n < 30000)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end

    initial
    begin
        logic [31:0] q;
        ref_clk_in = 1'b0;
        sys_rst_in = 1'b1;
        enable_in  = 1'b0;
        fb_pin     = 1'b1;
        num_errors = 0;
        checks     = 0;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        tick(2);
        for (int k = 0; k < 7; k++)
        begin
            rd(ra[k], q);
            chk(q, rv[k]);
            chk(hresp, 32'h0);
        end
        for (int k = 0; k < 6; k++)
        begin
            wr(`REG_CTRL, {30'h0, cd[k], 1'b0});
            wr(`REG_TARGET, cw[k]);
            rd(`REG_TARGET, q);
            chk(q, ce[k]);
        end
        wr(`REG_CTRL, 32'h1);
        wr(`REG_TARGET, 32'h65);
        tick(3);
        chk(dis_en, 32'h1);
        wr(`REG_DISCHARGE, 32'h2);
        tick(3);
        chk(dis_lvl, 32'h2);
        @(posedge ref_clk_in);
        enable_in <= 1'b1;
        tick(2);
        chk(run, 32'h1);
        chk(fb_int, 32'h1);
        @(posedge ref_clk_in);
        fb_pin <= 1'b0;
        tick(3);
        chk(dis_en, 32'h0);
        wait_ref(12'h065);
        chk(refc, 32'h65);
        chk(fb_int, 32'h1);
        rd(`REG_STATUS, q);
        chk(q, 32'h0065_0003);
        wr(`REG_TARGET, 32'h67);
        tick(260);
        chk(refc, 32'h66);
        tick(260);
        chk(refc, 32'h67);
        wr(`REG_RAMP_CFG, 32'h100);
        wr(`REG_TARGET, 32'h65);
        tick(260);
        chk(refc, 32'h66);
        chk(dis_en, 32'h1);
        chk(dis_lvl, 32'h3);
        tick(260);
        chk(refc, 32'h65);
        chk(dis_en, 32'h0);
        wr(`REG_RAMP_CFG, 32'h0);
        wr(`REG_TARGET, 32'h64);
        tick(130);
        chk(dis_en, 32'h0);
        tick(130);
        chk(refc, 32'h64);
        wr(`REG_CTRL, 32'h5);
        tick(3);
        chk(rev_blk, 32'h1);
        wr(`REG_DISCHARGE, 32'h6);
        tick(3);
        chk(dis_en, 32'h1);
        @(posedge ref_clk_in);
        enable_in <= 1'b0;
        tick(3);
        chk(run, 32'h0);
        chk(rev_blk, 32'h0);
        wr(`REG_DISCHARGE, 32'hA);
        tick(3);
        chk(dis_en, 32'h0);
        wr(`REG_DISCHARGE, 32'h2);
        tick(3);
        chk(dis_en, 32'h1);
        wr(`REG_DISCH_SEQ_A, 32'h0);
        tick(3);
        chk(dis_en, 32'h0);
        wr(`REG_DISCH_SEQ_B, 32'h1);
        wr(`REG_DISCH_SEQ_A, 32'h3);
        tick(3);
        chk(dis_en, 32'h0);
        tick(260);
        chk(dis_en, 32'h1);
        end_of_test();
    end
endmodule
